// ==== mph_pkg.sv ====
// ============================================================
// shared constants for the module power handshake
// ============================================================
package mph_pkg;

  // clock rate and timing figures
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned DEBOUNCE_US    = 1000;  // enable debounce, 1 ms
  localparam int unsigned MIN_LOW_US     = 100;   // least enable-low time
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned MIN_LOW_CYC    = MIN_LOW_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 20;

  // synchroniser pin group layout
  localparam int unsigned PIN_W          = 8;
  localparam int unsigned PIN_PWR_EN     = 0;
  localparam int unsigned PIN_RST_IN     = 1;
  localparam int unsigned PIN_SLEEP_WAKE = 2;
  localparam int unsigned PIN_STRAP_N    = 3;
  localparam int unsigned PIN_WAKE_LSB   = 4;
  localparam int unsigned WAKE_W         = 4;
  localparam logic [7:0]  PIN_RST_VAL    = 8'h0a;  // reset line and strap idle high

  // power domains
  localparam int unsigned DOM_W          = 4;
  localparam logic [3:0]  DOM_ALL_ON     = 4'hf;
  localparam logic [3:0]  DOM_SLEEP      = 4'h1;  // only the always-on island
  localparam logic [3:0]  DOM_OFF        = 4'h0;

  // power states
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_PWRUP = 3'b001,
    ST_ON    = 3'b010,
    ST_SLEEP = 3'b011
  } mph_state_t;

endpackage : mph_pkg

// ==== mph_pin_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// raw pins in, settled levels out
// ============================================================
interface mph_pin_if;
  logic [mph_pkg::PIN_W-1:0] raw;
  logic [mph_pkg::PIN_W-1:0] clean;
  modport sync_side (input raw, output clean);
  modport core_side (output raw, input clean);
endinterface : mph_pin_if
`default_nettype wire

// ==== mph_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// three-flop synchroniser with agreement filter
// ============================================================
module mph_sync
#(
  parameter int unsigned          W       = 8,
  parameter logic [W-1:0]         RST_VAL = '0
)
(
  input  wire logic               clk,
  input  wire logic               nrst,
  mph_pin_if.sync_side            pins
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // a bit only moves once flops two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  // first flop feeds only the second
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      out_q <= RST_VAL;
    end
    else
    begin
      s1_q  <= pins.raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pins.clean = out_q;

endmodule : mph_sync
`default_nettype wire

// ==== mph_power_handshake.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - shutdown_request_n low asks carrier for shutdown
// - release reset only after power-up finishes
// - reset covers module logic and storage
// - module_sleep_n low only in deep sleep
// - sleep_wake_request asks sleep entry or exit
// - enabled wake source resumes from deep sleep
// - gate idle domains, hold states in sleep
// - low recovery strap forces recovery boot
// - enable removed, module asserts system_reset_n
// - enable low 100 us starts hardware shutdown
// - debounce power enable for 1 ms
module mph_power_handshake
#(
  parameter int unsigned DEBOUNCE_CYC = mph_pkg::DEBOUNCE_CYC,
  parameter int unsigned MIN_LOW_CYC  = mph_pkg::MIN_LOW_CYC
)
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      module_power_enable,
  input  wire logic                      system_reset_n_i,
  output var  logic                      system_reset_n_o,
  output var  logic                      system_reset_n_oe,
  output var  logic                      shutdown_request_n,
  output var  logic                      module_sleep_n,
  input  wire logic                      sleep_wake_request,
  input  wire logic                      recovery_strap_n,
  input  wire logic [mph_pkg::WAKE_W-1:0] wake_src,
  input  wire logic [mph_pkg::WAKE_W-1:0] wake_enable,
  input  wire logic                      shutdown_event,
  input  wire logic                      power_seq_done,
  input  wire logic [mph_pkg::DOM_W-1:0]  domain_idle,
  output var  logic [mph_pkg::DOM_W-1:0]  domain_power_en,
  output var  logic                      core_reset_n,
  output var  logic                      storage_reset_n,
  output var  logic                      hold_io_state,
  output var  logic                      recovery_boot
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  mph_pin_if pins ();

  assign pins.raw = {wake_src, recovery_strap_n, sleep_wake_request,
                     system_reset_n_i, module_power_enable};

  mph_sync #(.W(mph_pkg::PIN_W), .RST_VAL(mph_pkg::PIN_RST_VAL)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .pins (pins)
  );

  logic                       en_s;
  logic                       rst_in_s;
  logic                       sw_s;
  logic                       strap_n_s;
  logic [mph_pkg::WAKE_W-1:0] wake_s;

  assign en_s      = pins.clean[mph_pkg::PIN_PWR_EN];
  assign rst_in_s  = pins.clean[mph_pkg::PIN_RST_IN];
  assign sw_s      = pins.clean[mph_pkg::PIN_SLEEP_WAKE];
  assign strap_n_s = pins.clean[mph_pkg::PIN_STRAP_N];
  assign wake_s    = pins.clean[mph_pkg::PIN_WAKE_LSB +: mph_pkg::WAKE_W];

  // ==========================================================
  // enable debounce and low-time measurement
  // ==========================================================
  logic [mph_pkg::CNT_W-1:0] deb_cnt_q;
  logic [mph_pkg::CNT_W-1:0] deb_cnt_d;
  logic                      en_deb_q;
  logic                      en_deb_d;
  logic [mph_pkg::CNT_W-1:0] low_cnt_q;
  logic [mph_pkg::CNT_W-1:0] low_cnt_d;
  logic                      hw_shut;

  // counter end points, cut to the counter width on purpose
  localparam int unsigned               DEB_M1   = DEBOUNCE_CYC - 1;
  localparam int unsigned               LOW_M1   = MIN_LOW_CYC - 1;
  localparam logic [mph_pkg::CNT_W-1:0] DEB_LAST = DEB_M1[mph_pkg::CNT_W-1:0];
  localparam logic [mph_pkg::CNT_W-1:0] LOW_LAST = LOW_M1[mph_pkg::CNT_W-1:0];

  // any glitch back to the settled level restarts the count
  always_comb
  begin
    en_deb_d  = en_deb_q;
    deb_cnt_d = '0;
    low_cnt_d = '0;
    hw_shut   = 1'b0;
    if (en_s != en_deb_q)
    begin
      if (deb_cnt_q == DEB_LAST)
      begin
        en_deb_d = en_s;
      end
      else
      begin
        deb_cnt_d = deb_cnt_q + 1'b1;
      end
    end
    if (!en_s)
    begin
      if (low_cnt_q == LOW_LAST)
      begin
        hw_shut   = 1'b1;
        low_cnt_d = low_cnt_q;                          // saturate
      end
      else
      begin
        low_cnt_d = low_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      deb_cnt_q <= '0;
      en_deb_q  <= 1'b0;
      low_cnt_q <= '0;
    end
    else
    begin
      deb_cnt_q <= deb_cnt_d;
      en_deb_q  <= en_deb_d;
      low_cnt_q <= low_cnt_d;
    end
  end

  // ==========================================================
  // power state machine and registered outputs
  // ==========================================================
  localparam mph_pkg::mph_state_t ST_OFF   = mph_pkg::ST_OFF;
  localparam mph_pkg::mph_state_t ST_PWRUP = mph_pkg::ST_PWRUP;
  localparam mph_pkg::mph_state_t ST_ON    = mph_pkg::ST_ON;
  localparam mph_pkg::mph_state_t ST_SLEEP = mph_pkg::ST_SLEEP;

  mph_pkg::mph_state_t         st_q;
  mph_pkg::mph_state_t         st_d;
  logic                        sw_prev_q;
  logic                        pend_q;
  logic                        pend_d;
  logic                        oe_q;
  logic                        oe_d;
  logic                        sleep_n_q;
  logic                        sleep_n_d;
  logic [4:0]                  oe_hist_q;
  logic [4:0]                  oe_hist_d;
  logic                        sreq_n_q;
  logic                        rst_n_q;
  logic                        hold_q;
  logic [mph_pkg::DOM_W-1:0]   dom_q;
  logic [mph_pkg::DOM_W-1:0]   dom_d;
  logic                        rec_q;
  logic                        rec_d;
  logic                        ext_rst;
  logic                        wake_hit;

  // carrier reset only seen once our own release has crossed the synchroniser,
  // else the stale low read-back would look like a carrier reset
  assign ext_rst  = !oe_q && (oe_hist_q == 5'h00) && !rst_in_s;
  assign wake_hit = |(wake_s & wake_enable) || (sw_prev_q && !sw_s);

  always_comb
  begin
    st_d  = st_q;
    rec_d = rec_q;
    unique case (st_q)
      ST_OFF:
      begin
        if (en_deb_q)
        begin
          st_d  = ST_PWRUP;
          rec_d = !strap_n_s;
        end
      end
      ST_PWRUP:
      begin
        if (!en_deb_q)
        begin
          st_d = ST_OFF;
        end
        else if (power_seq_done)
        begin
          st_d = ST_ON;
        end
      end
      ST_ON:
      begin
        if (!en_deb_q)
        begin
          st_d = ST_OFF;
        end
        else if (ext_rst)
        begin
          st_d = ST_PWRUP;
        end
        else if (sw_s && !sw_prev_q)
        begin
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (!en_deb_q)
        begin
          st_d = ST_OFF;
        end
        else if (ext_rst)
        begin
          st_d = ST_PWRUP;
        end
        else if (wake_hit)
        begin
          st_d = ST_ON;
        end
      end
      default:
      begin
        st_d = ST_OFF;
      end
    endcase
  end

  // outputs other than shutdown_request_n follow the next state so they land with it
  always_comb
  begin
    oe_d   = (st_d == ST_OFF) || (st_d == ST_PWRUP);
    sleep_n_d = (st_d != ST_SLEEP);
    oe_hist_d = {oe_hist_q[3:0], oe_q};
    // off clears, and wins over a set in the same cycle
    pend_d = (pend_q || shutdown_event || hw_shut) && (st_q != ST_OFF);
    unique case (st_d)
      ST_ON:    dom_d = ~domain_idle;
      ST_SLEEP: dom_d = mph_pkg::DOM_SLEEP;
      ST_PWRUP: dom_d = mph_pkg::DOM_ALL_ON;
      default:  dom_d = mph_pkg::DOM_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q      <= ST_OFF;
      sw_prev_q <= 1'b0;
      pend_q    <= 1'b0;
      oe_q      <= 1'b1;
      sleep_n_q <= 1'b1;
      oe_hist_q <= 5'h1f;
      sreq_n_q  <= 1'b1;
      rst_n_q   <= 1'b0;
      hold_q    <= 1'b0;
      dom_q     <= mph_pkg::DOM_OFF;
      rec_q     <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      sw_prev_q <= sw_s;
      pend_q    <= pend_d;
      oe_q      <= oe_d;
      sleep_n_q <= sleep_n_d;
      oe_hist_q <= oe_hist_d;
      sreq_n_q  <= !pend_d;
      rst_n_q   <= !oe_d;
      hold_q    <= !sleep_n_d;
      dom_q     <= dom_d;
      rec_q     <= rec_d;
    end
  end

  // open drain: the pin value is always low, only the enable moves
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      system_reset_n_o <= 1'b0;
    end
    else
    begin
      system_reset_n_o <= 1'b0;
    end
  end

  assign system_reset_n_oe  = oe_q;
  assign shutdown_request_n = sreq_n_q;
  assign module_sleep_n     = sleep_n_q;
  assign domain_power_en    = dom_q;
  assign core_reset_n       = rst_n_q;
  assign storage_reset_n    = rst_n_q;
  assign hold_io_state      = hold_q;
  assign recovery_boot      = rec_q;

  // ==========================================================
  // assertions
  // ==========================================================
  property p_shut_req;
    @(posedge clk) disable iff (!nrst)
    (shutdown_event && st_q != ST_OFF) |=> !shutdown_request_n;
  endproperty
  a_shut_req: assert property (p_shut_req) else $error("shutdown request not raised");

  property p_shut_idle;
    @(posedge clk) disable iff (!nrst)
    (st_q == ST_OFF) |=> shutdown_request_n || $past(shutdown_event) || $past(hw_shut);
  endproperty
  a_shut_idle: assert property (p_shut_idle) else $error("stray shutdown request");

  property p_release;
    @(posedge clk) disable iff (!nrst)
    $fell(system_reset_n_oe) |-> $past(st_q) == ST_PWRUP && $past(power_seq_done);
  endproperty
  a_release: assert property (p_release) else $error("reset released too early");

  property p_off_reset;
    @(posedge clk) disable iff (!nrst)
    (st_q == ST_ON && !en_deb_q) |=> system_reset_n_oe && st_q == ST_OFF;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("reset not asserted on disable");

  property p_ext_reset;
    @(posedge clk) disable iff (!nrst)
    (st_q == ST_ON && en_deb_q && ext_rst) |=> !core_reset_n ##0 !storage_reset_n;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("carrier reset ignored");

  property p_sleep_pin;
    @(posedge clk) disable iff (!nrst)
    (st_q == ST_SLEEP) == !module_sleep_n;
  endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("sleep pin mismatch");

  property p_wake;
    @(posedge clk) disable iff (!nrst)
    (st_q == ST_SLEEP && en_deb_q && !ext_rst && |(wake_s & wake_enable))
      |=> st_q == ST_ON ##1 module_sleep_n;
  endproperty
  a_wake: assert property (p_wake) else $error("enabled wake lost");

  property p_gate;
    @(posedge clk) disable iff (!nrst)
    (st_q == ST_SLEEP) |-> domain_power_en == mph_pkg::DOM_SLEEP && hold_io_state;
  endproperty
  a_gate: assert property (p_gate) else $error("sleep domains wrong");

  property p_strap;
    @(posedge clk) disable iff (!nrst)
    (st_q == ST_OFF && en_deb_q) |=> recovery_boot == !$past(strap_n_s);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");

  property p_hw_shut;
    @(posedge clk) disable iff (!nrst)
    (low_cnt_q == LOW_LAST && !en_s && st_q != ST_OFF)
      |=> !shutdown_request_n;
  endproperty
  a_hw_shut: assert property (p_hw_shut) else $error("hardware shutdown missed");

  property p_debounce;
    @(posedge clk) disable iff (!nrst)
    $changed(en_deb_q) |-> $past(deb_cnt_q) == DEB_LAST;
  endproperty
  a_debounce: assert property (p_debounce) else $error("enable moved before debounce");

  property p_cov_on;
    @(posedge clk) disable iff (!nrst)
    st_q == ST_PWRUP ##1 st_q == ST_ON;
  endproperty
  c_cov_on: cover property (p_cov_on);

  property p_cov_sleep;
    @(posedge clk) disable iff (!nrst)
    st_q == ST_SLEEP ##1 st_q == ST_ON;
  endproperty
  c_cov_sleep: cover property (p_cov_sleep);

  property p_cov_off;
    @(posedge clk) disable iff (!nrst)
    !shutdown_request_n ##[1:300] st_q == ST_OFF;
  endproperty
  c_cov_off: cover property (p_cov_off);

endmodule : mph_power_handshake
`default_nettype wire

// ==== mph_carrier_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// carrier board side of the power and reset handshake
// ============================================================
module mph_carrier_model
#(
  parameter int unsigned MIN_LOW = 4
)
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic want_on,
  input  wire logic carrier_reset,
  input  wire logic system_reset_n_oe,
  input  wire logic shutdown_request_n,
  output var  logic module_power_enable,
  output wire logic system_reset_n_i,
  output var  logic supply_on
);
  logic [7:0] low_cnt_q;

  // shared line with pull-up: low whenever either side pulls it
  assign system_reset_n_i = !(system_reset_n_oe || carrier_reset);

  // enable follows the bench, drops at once on a request, stays low long enough
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      module_power_enable <= 1'b0;
      low_cnt_q           <= 8'h00;
      supply_on           <= 1'b0;
    end
    else
    begin
      if (module_power_enable)
      begin
        if (!want_on || !shutdown_request_n)
          module_power_enable <= 1'b0;
        low_cnt_q <= 8'h00;
      end
      else if (low_cnt_q < 8'(MIN_LOW))
        low_cnt_q <= low_cnt_q + 8'h01;
      else if (want_on && shutdown_request_n)
        module_power_enable <= 1'b1;
      // own supplies only once the module has let the line go high
      supply_on <= module_power_enable && system_reset_n_i;
    end
  end
endmodule : mph_carrier_model
`default_nettype wire

// ==== mph_power_handshake_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench for the power handshake, short counts
// ============================================================
module mph_power_handshake_tb_top;
  logic       clk;
  logic       nrst;
  logic       want_on;
  logic       carrier_reset;
  logic       en;
  wire logic  line;
  logic       oe;
  logic       rst_o;
  logic       sreq_n;
  logic       sleep_n;
  logic       swr;
  logic       strap_n;
  logic [3:0] wake_src;
  logic [3:0] wake_en;
  logic       sd_ev;
  logic       seq_done;
  logic [3:0] idle;
  logic [3:0] dom;
  logic       core_n;
  logic       stor_n;
  logic       hold;
  logic       rboot;
  logic       supply;
  int         mismatches;
  int         tests_run;

  mph_power_handshake #(.DEBOUNCE_CYC(16), .MIN_LOW_CYC(4)) i_mph_power_handshake (
    .clk(clk), .nrst(nrst), .module_power_enable(en), .system_reset_n_i(line),
    .system_reset_n_o(rst_o), .system_reset_n_oe(oe), .shutdown_request_n(sreq_n),
    .module_sleep_n(sleep_n), .sleep_wake_request(swr), .recovery_strap_n(strap_n),
    .wake_src(wake_src), .wake_enable(wake_en), .shutdown_event(sd_ev),
    .power_seq_done(seq_done), .domain_idle(idle), .domain_power_en(dom),
    .core_reset_n(core_n), .storage_reset_n(stor_n), .hold_io_state(hold),
    .recovery_boot(rboot));

  mph_carrier_model #(.MIN_LOW(4)) i_mph_carrier_model (
    .clk(clk), .nrst(nrst), .want_on(want_on), .carrier_reset(carrier_reset),
    .system_reset_n_oe(oe), .shutdown_request_n(sreq_n), .module_power_enable(en),
    .system_reset_n_i(line), .supply_on(supply));

  // ============================================================
  // shared tasks
  // ============================================================
  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // bounded wait: 0 oe, 1 sleep_n, 2 shutdown request, 3 all domains on
  task automatic wait_sig(input int which, input logic val, input int lim);
    logic cur;
    int   n;
    n = 0;
    cur = ~val;
    while (cur !== val && n < lim)
    begin
      @(negedge clk);
      n++;
      case (which)
        0:       cur = oe;
        1:       cur = sleep_n;
        2:       cur = sreq_n;
        default: cur = (dom === 4'hf);
      endcase
    end
    check({3'h0, cur}, {3'h0, val}, "bounded wait");
  endtask : wait_sig

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ============================================================
  // scenarios
  // ============================================================
  task automatic t_power_up(input logic strap, input logic exp_boot);
    strap_n = strap;
    want_on = 1'b1;
    wait_sig(3, 1'b1, 60);
    check(oe, 4'h1, "line held in power-up");
    repeat (3) @(negedge clk);
    check(supply, 4'h0, "carrier waits");
    check(rboot, exp_boot, "recovery strap");
    seq_done = 1'b1;
    wait_sig(0, 1'b0, 4);
    check(core_n, 4'h1, "core out of reset");
    check(stor_n, 4'h1, "storage out of reset");
    check(dom, 4'ha, "idle domains gated");
    repeat (2) @(negedge clk);
    check(supply, 4'h1, "carrier supply on");
    check(sreq_n, 4'h1, "no request when on");
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_sleep;
    for (int i = 0; i < 4; i++)
    begin
      swr = 1'b1;
      wait_sig(1, 1'b0, 12);
      check(hold, 4'h1, "io held in sleep");
      check(dom, 4'h1, "sleep domains");
      wake_src = 4'h1 << i;
      wake_en = ~(4'h1 << i);
      repeat (10) @(negedge clk);
      check(sleep_n, 4'h0, "masked wake ignored");
      wake_en = 4'hf;
      wait_sig(1, 1'b1, 12);
      check(dom, 4'ha, "domains after wake");
      wake_src = 4'h0;
      swr = 1'b0;
      repeat (8) @(negedge clk);
    end
    swr = 1'b1;
    wait_sig(1, 1'b0, 12);
    swr = 1'b0;
    wait_sig(1, 1'b1, 12);
    check(hold, 4'h0, "io free when awake");
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_carrier_reset;
    seq_done = 1'b0;
    carrier_reset = 1'b1;
    wait_sig(0, 1'b1, 8);
    check(core_n, 4'h0, "core reset");
    check(stor_n, 4'h0, "storage reset");
    carrier_reset = 1'b0;
    repeat (4) @(negedge clk);
    check(oe, 4'h1, "held until sequence done");
    check(supply, 4'h0, "supply follows line");
    seq_done = 1'b1;
    wait_sig(0, 1'b0, 4);
    check(core_n, 4'h1, "core released");
    $display("test carrier_reset done");
  endtask : t_carrier_reset

  task automatic t_sw_shutdown;
    sd_ev = 1'b1;
    @(negedge clk);
    sd_ev = 1'b0;
    wait_sig(2, 1'b0, 4);
    want_on = 1'b0;
    wait_sig(0, 1'b1, 40);
    check(core_n, 4'h0, "core reset in off");
    check(dom, 4'h0, "domains off");
    wait_sig(2, 1'b1, 4);
    seq_done = 1'b0;
    $display("test sw_shutdown done");
  endtask : t_sw_shutdown

  task automatic t_hw_shutdown;
    want_on = 1'b0;
    repeat (8) @(negedge clk);
    want_on = 1'b1;
    check(oe, 4'h0, "short low not acted on");
    wait_sig(2, 1'b0, 8);
    check(oe, 4'h0, "request before off");
    want_on = 1'b0;
    wait_sig(0, 1'b1, 40);
    check(stor_n, 4'h0, "storage reset in off");
    check(rst_o, 4'h0, "line driven low");
    wait_sig(2, 1'b1, 4);
    $display("test hw_shutdown done");
  endtask : t_hw_shutdown

  // ============================================================
  // clock, watchdog and main sequence
  // ============================================================
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // a hang is cut short well beyond the expected run length
  initial
  begin
    repeat (6000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    mismatches = 0;
    tests_run = 0;
    nrst = 1'b0;
    want_on = 1'b0;
    carrier_reset = 1'b0;
    swr = 1'b0;
    strap_n = 1'b1;
    wake_src = 4'h0;
    wake_en = 4'h0;
    sd_ev = 1'b0;
    seq_done = 1'b0;
    idle = 4'h5;
    repeat (10) @(negedge clk);
    check(oe, 4'h1, "reset pulls line");
    check(core_n, 4'h0, "core in reset");
    check(sleep_n, 4'h1, "not asleep");
    check(sreq_n, 4'h1, "no request in reset");
    nrst = 1'b1;
    t_power_up(1'b0, 1'b1);
    t_sleep();
    t_carrier_reset();
    t_sw_shutdown();
    t_power_up(1'b1, 1'b0);
    t_hw_shutdown();
    tally_and_finish();
  end
endmodule : mph_power_handshake_tb_top
`default_nettype wire
